// *** src/asp_defines.vh ***
// Constants for the converter serial port and latch pin block.
// Assumes inclusion by bare name from design files under src/.
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH

// ==========================================================
// Word sizes and buffer depth
`define ASP_CMD_BITS 8
`define ASP_WORD_BITS 24
`define ASP_FIFO_DEPTH 32

// ==========================================================
// Configuration register fields and reset value
`define ASP_CFG_RESET 24'h00_0000
`define ASP_CFG_ALATCH_LO 22
`define ASP_CFG_DLATCH_LO 18
`define ASP_CFG_POLARITY 10

// ==========================================================
// Command bytes
`define ASP_CMD_NULL 8'h00
`define ASP_CMD_WR_CFG 8'h03
`define ASP_CMD_RD_CFG 8'h0B
`define ASP_CMD_CONT 8'hA0

`endif

// *** src/asp_fifo.v ***
// Word FIFO with registered read data and valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module asp_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	// Clock and reset
	input wire i_clk,
	input wire i_arst_n,
	// Fill side
	input wire [WIDTH-1:0] i_wr_data,
	input wire i_wr_valid,
	output reg o_wr_ready,
	// Drain side
	output reg [WIDTH-1:0] o_rd_data,
	output reg o_rd_valid,
	input wire i_rd_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] cnt;
	wire push = i_wr_valid & o_wr_ready;
	// Output stage refills when empty or being drained
	wire load = (cnt != {(AW+1){1'b0}}) & (~o_rd_valid | i_rd_ready);
	wire [AW:0] next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

	// ==========================================================
	// Storage; no reset so it maps onto plain memory
	always @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_wr_data;
		end
	end

	// ==========================================================
	// Pointers, fill count and registered read stage
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
			o_wr_ready <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
			end
			if (load) begin
				rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
				o_rd_data <= mem[rd_ptr];
				o_rd_valid <= 1'b1;
			end else if (i_rd_ready) begin
				o_rd_valid <= 1'b0;
			end
			cnt <= next_cnt;
			// Ready is a flop fed from the next count so the source sees full with no lag
			o_wr_ready <= (next_cnt < DEPTH[AW:0]);
		end
	end

endmodule // asp_fifo
`default_nettype wire

// *** src/asp_top.v ***
// Serial port and latch pins of a delta-sigma converter, device side.
// Assumes chip select, serial clock and serial input arrive from a host
// on another clock; conversion words arrive from on-chip logic.
`timescale 1ns/100ps
`default_nettype none
`include "asp_defines.vh"

module asp_top #(
	parameter WORD_BITS = `ASP_WORD_BITS,
	parameter FIFO_DEPTH = `ASP_FIFO_DEPTH
) (
	// Clock and reset
	input wire I_CORE_CLK,
	input wire I_ARST_N,
	// Host serial pins
	input wire I_CS_N,
	input wire I_SCLK,
	input wire I_SERIAL_IN,
	output reg O_SERIAL_OUT,
	output reg O_SERIAL_OUT_OE_N,
	// Conversion words from the filter
	input wire [WORD_BITS-1:0] I_CONV_DATA,
	input wire I_CONV_VALID,
	output wire O_CONV_READY,
	// Latch pins
	output reg O_ANALOG_LATCH_OUT_0,
	output reg O_ANALOG_LATCH_OUT_1,
	output reg O_DIGITAL_LATCH_OUT_0,
	output reg O_DIGITAL_LATCH_OUT_1,
	output reg O_DIGITAL_LATCH_OUT_2,
	output reg O_DIGITAL_LATCH_OUT_3,
	// Status
	output reg O_UNIPOLAR,
	output reg O_CONT_MODE,
	output reg [WORD_BITS-1:0] O_CFG
);
	// ==========================================================
	// Port states, one-hot
	localparam [4:0] ST_CMD = 5'b0_0001;
	localparam [4:0] ST_WR = 5'b0_0010;
	localparam [4:0] ST_RD = 5'b0_0100;
	localparam [4:0] ST_FLAG = 5'b0_1000;
	localparam [4:0] ST_DATA = 5'b1_0000;
	localparam [4:0] CNT_CMD_LAST = 5'h07;
	localparam [4:0] CNT_WORD_LAST = 5'h17;

	// Synchronisers and edge finder
	reg cs_q1;
	reg cs_q2;
	reg sclk_q1;
	reg sclk_q2;
	reg sclk_q3;
	reg sdi_q1;
	reg sdi_q2;
	// Port state
	reg [4:0] state;
	reg [4:0] bit_cnt;
	reg [WORD_BITS-1:0] in_sh;
	reg [WORD_BITS-1:0] out_sh;
	reg [WORD_BITS-1:0] cfg;
	reg cont;
	// FIFO drain side
	wire [WORD_BITS-1:0] fifo_data;
	wire fifo_valid;
	reg fifo_pop;

	wire sel = ~cs_q2;
	// Edges count only while selected
	wire rise = sel & sclk_q2 & ~sclk_q3;
	wire fall = sel & ~sclk_q2 & sclk_q3;
	wire [7:0] cmd_byte = {in_sh[6:0], sdi_q2};

	// ==========================================================
	// Command decode, used from the idle and flag states
	function [4:0] cmd_state;
		input [7:0] cmd;
		begin
			if (cmd == `ASP_CMD_WR_CFG) begin
				cmd_state = ST_WR;
			end else if (cmd == `ASP_CMD_RD_CFG) begin
				cmd_state = ST_RD;
			end else begin
				cmd_state = ST_CMD;
			end
		end
	endfunction

	// ==========================================================
	// Two-stage synchronisers; stage two feeds logic, plus a third serial clock stage for the edge finder
	always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			cs_q1 <= 1'b1;
			cs_q2 <= 1'b1;
			sclk_q1 <= 1'b0;
			sclk_q2 <= 1'b0;
			sclk_q3 <= 1'b0;
			sdi_q1 <= 1'b0;
			sdi_q2 <= 1'b0;
		end else begin
			cs_q1 <= I_CS_N;
			cs_q2 <= cs_q1;
			sclk_q1 <= I_SCLK;
			sclk_q2 <= sclk_q1;
			sclk_q3 <= sclk_q2;
			sdi_q1 <= I_SERIAL_IN;
			sdi_q2 <= sdi_q1;
		end
	end

	// ==========================================================
	// Conversion word buffer between filter and port
	asp_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(FIFO_DEPTH),
		.AW(5)
	) u_fifo (
		.i_clk(I_CORE_CLK),
		.i_arst_n(I_ARST_N),
		.i_wr_data(I_CONV_DATA),
		.i_wr_valid(I_CONV_VALID),
		.o_wr_ready(O_CONV_READY),
		.o_rd_data(fifo_data),
		.o_rd_valid(fifo_valid),
		.i_rd_ready(fifo_pop)
	);

	// ==========================================================
	// Port state machine
	always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state <= ST_CMD;
			bit_cnt <= 5'h00;
			in_sh <= {WORD_BITS{1'b0}};
			out_sh <= {WORD_BITS{1'b0}};
			cfg <= `ASP_CFG_RESET;
			cont <= 1'b0;
			fifo_pop <= 1'b0;
		end else begin
			fifo_pop <= 1'b0;
			if (!sel) begin
				// Frame ends with chip select; a pending flag survives
				bit_cnt <= 5'h00;
				if (state != ST_FLAG) begin
					state <= ST_CMD;
				end
			end
			case (state)
				ST_CMD: begin
					if (rise) begin
						in_sh <= {in_sh[WORD_BITS-2:0], sdi_q2};
						bit_cnt <= bit_cnt + 5'h01;
						if (bit_cnt == CNT_CMD_LAST) begin
							bit_cnt <= 5'h00;
							state <= cmd_state(cmd_byte);
							if (cmd_byte == `ASP_CMD_RD_CFG) begin
								out_sh <= cfg;
							end
							if (cmd_byte == `ASP_CMD_CONT) begin
								cont <= 1'b1;
							end
						end
					end else if (cont && fifo_valid && !fifo_pop &&
						bit_cnt == 5'h00) begin
						// Take a finished word and raise the ready flag
						out_sh <= fifo_data;
						fifo_pop <= 1'b1;
						state <= ST_FLAG;
					end
				end
				ST_FLAG: begin
					if (rise) begin
						in_sh <= {in_sh[WORD_BITS-2:0], sdi_q2};
						bit_cnt <= bit_cnt + 5'h01;
						if (bit_cnt == CNT_CMD_LAST) begin
							bit_cnt <= 5'h00;
							if (cmd_byte == `ASP_CMD_NULL) begin
								state <= ST_DATA;
							end else begin
								// Any real command taken at the flag leaves continuous mode
								cont <= 1'b0;
								state <= cmd_state(cmd_byte);
								if (cmd_byte == `ASP_CMD_RD_CFG) begin
									out_sh <= cfg;
								end
							end
						end
					end
				end
				ST_WR: begin
					if (rise) begin
						in_sh <= {in_sh[WORD_BITS-2:0], sdi_q2};
						bit_cnt <= bit_cnt + 5'h01;
						if (bit_cnt == CNT_WORD_LAST) begin
							bit_cnt <= 5'h00;
							cfg <= {in_sh[WORD_BITS-2:0], sdi_q2};
							state <= ST_CMD;
						end
					end
				end
				ST_RD, ST_DATA: begin
					if (fall) begin
						out_sh <= {out_sh[WORD_BITS-2:0], 1'b0};
					end
					if (rise) begin
						bit_cnt <= bit_cnt + 5'h01;
						if (bit_cnt == CNT_WORD_LAST) begin
							bit_cnt <= 5'h00;
							state <= ST_CMD;
						end
					end
				end
				default: begin
					state <= ST_CMD;
				end
			endcase
		end
	end

	// ==========================================================
	// Serial output and its enable, low enable drives the pin
	always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_SERIAL_OUT <= 1'b1;
			O_SERIAL_OUT_OE_N <= 1'b1;
		end else begin
			O_SERIAL_OUT_OE_N <= cs_q2;
			if (state == ST_FLAG) begin
				O_SERIAL_OUT <= 1'b0;
			end else if ((state == ST_RD || state == ST_DATA) && fall) begin
				// MSB leaves on the first falling edge of the word
				O_SERIAL_OUT <= out_sh[WORD_BITS-1];
			end else if (state == ST_CMD || state == ST_WR) begin
				O_SERIAL_OUT <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Latch pins and status, one cycle after the write lands
	always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_ANALOG_LATCH_OUT_0 <= 1'b0;
			O_ANALOG_LATCH_OUT_1 <= 1'b0;
			O_DIGITAL_LATCH_OUT_0 <= 1'b0;
			O_DIGITAL_LATCH_OUT_1 <= 1'b0;
			O_DIGITAL_LATCH_OUT_2 <= 1'b0;
			O_DIGITAL_LATCH_OUT_3 <= 1'b0;
			O_UNIPOLAR <= 1'b0;
			O_CONT_MODE <= 1'b0;
			O_CFG <= `ASP_CFG_RESET;
		end else begin
			O_ANALOG_LATCH_OUT_0 <= cfg[`ASP_CFG_ALATCH_LO];
			O_ANALOG_LATCH_OUT_1 <= cfg[`ASP_CFG_ALATCH_LO+1];
			O_DIGITAL_LATCH_OUT_0 <= cfg[`ASP_CFG_DLATCH_LO];
			O_DIGITAL_LATCH_OUT_1 <= cfg[`ASP_CFG_DLATCH_LO+1];
			O_DIGITAL_LATCH_OUT_2 <= cfg[`ASP_CFG_DLATCH_LO+2];
			O_DIGITAL_LATCH_OUT_3 <= cfg[`ASP_CFG_DLATCH_LO+3];
			// Set selects unipolar coding, clear selects bipolar
			O_UNIPOLAR <= cfg[`ASP_CFG_POLARITY];
			O_CONT_MODE <= cont;
			O_CFG <= cfg;
		end
	end

endmodule // asp_top
`default_nettype wire

// *** verif/asp_top_sva.sv ***
// Checker for the converter serial port and latch pins.
// Assumes it is bound onto asp_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
// ==========
// Port checks
module asp_top_sva #(
	parameter WORD_BITS = 24
) (
	// Clock, reset and host pins
	input wire logic I_CORE_CLK,
	input wire logic I_ARST_N,
	input wire logic I_CS_N,
	input wire logic I_SCLK,
	input wire logic O_SERIAL_OUT,
	input wire logic O_SERIAL_OUT_OE_N,
	// Latch pins and status
	input wire logic O_ANALOG_LATCH_OUT_0,
	input wire logic O_ANALOG_LATCH_OUT_1,
	input wire logic O_DIGITAL_LATCH_OUT_0,
	input wire logic O_DIGITAL_LATCH_OUT_1,
	input wire logic O_DIGITAL_LATCH_OUT_2,
	input wire logic O_DIGITAL_LATCH_OUT_3,
	input wire logic O_UNIPOLAR,
	input wire logic O_CONT_MODE,
	input wire logic [WORD_BITS-1:0] O_CFG
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_ARST_N);
	// Enable trails chip select by three cycles, two sync stages and the output flop; no margin
	AST_OE_OFF: assert property (I_CS_N [*4] |-> O_SERIAL_OUT_OE_N)
		else $error("serial out driven while deselected");
	AST_OE_ON: assert property ((!I_CS_N) [*4] |-> !O_SERIAL_OUT_OE_N)
		else $error("serial out not driven while selected");
	// Pins mirror the stored word at all times
	AST_A_LATCH: assert property ({O_ANALOG_LATCH_OUT_1, O_ANALOG_LATCH_OUT_0} == O_CFG[23:22])
		else $error("analog latch pins differ from config");
	AST_D_LATCH: assert property ({O_DIGITAL_LATCH_OUT_3, O_DIGITAL_LATCH_OUT_2,
		O_DIGITAL_LATCH_OUT_1, O_DIGITAL_LATCH_OUT_0} == O_CFG[21:18])
		else $error("digital latch pins differ from config");
	AST_POLARITY: assert property (O_UNIPOLAR == O_CFG[10])
		else $error("polarity flag differs from config");
	// No change without a selected, moving serial clock; serial out is held only outside continuous mode
	AST_NO_SEL_HOLD: assert property (I_CS_N [*8] |-> $stable(O_CFG))
		else $error("config changed while deselected");
	AST_IDLE_HOLD: assert property ($stable(I_SCLK) [*8] |-> $stable({O_CFG, O_UNIPOLAR}))
		else $error("config changed without serial clock");
	AST_SDO_HOLD: assert property (($stable(I_SCLK) && $stable(I_CS_N) && !O_CONT_MODE) [*8]
		|=> $stable(O_SERIAL_OUT))
		else $error("serial out moved without a clock edge");
endmodule // asp_top_sva
bind asp_top asp_top_sva #(.WORD_BITS(WORD_BITS)) u_asp_top_sva (.I_CORE_CLK, .I_ARST_N,
	.I_CS_N, .I_SCLK, .O_SERIAL_OUT, .O_SERIAL_OUT_OE_N, .O_ANALOG_LATCH_OUT_0,
	.O_ANALOG_LATCH_OUT_1, .O_DIGITAL_LATCH_OUT_0, .O_DIGITAL_LATCH_OUT_1,
	.O_DIGITAL_LATCH_OUT_2, .O_DIGITAL_LATCH_OUT_3, .O_UNIPOLAR, .O_CONT_MODE, .O_CFG);
`default_nettype wire

// *** verif/asp_host.sv ***
// Host model driving the three-wire port, 200 ns serial clock.
// Assumes the bench resolves the serial out pin before it arrives.
`timescale 1ns/100ps
`default_nettype none
// ==========
// Host
module asp_host (
	// Clock
	input wire logic i_clk,
	// Serial lines
	input wire logic i_sdo,
	output var logic o_cs_n,
	output var logic o_sclk,
	output var logic o_sdi
);
	// Idle deselected with the clock parked low
	initial begin
		o_cs_n = 1;
		o_sclk = 0;
		o_sdi = 0;
	end
	// One frame of n bits, MSB first; cs high sends clocks unselected
	task automatic xfer(input logic [31:0] tx, input int n, input logic cs,
		output logic [31:0] rx);
		rx = 0;
		o_cs_n <= cs;
		repeat (4) @(posedge i_clk);
		for (int k = n - 1; k >= 0; k--) begin
			o_sdi <= tx[k];
			repeat (4) @(posedge i_clk);
			o_sclk <= 1;
			rx = {rx[30:0], i_sdo};
			repeat (4) @(posedge i_clk);
			o_sclk <= 0;
		end
		repeat (4) @(posedge i_clk);
		o_cs_n <= 1;
		o_sdi <= ~o_sdi;
		repeat (8) @(posedge i_clk);
	endtask
endmodule // asp_host
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the serial port, latch pins and word buffer.
// Assumes asp_top with its checker bound and the asp_host model.
`timescale 1ns/100ps
`default_nettype none
// ==========
// Bench
module tb_top;
	logic clk = 0;
	logic rst_n = 0;
	logic vld = 0;
	logic [23:0] din = 0;
	logic [23:0] cfg = 0;
	logic [31:0] rx;
	logic [31:0] seed = 32'h23fb_df92;
	logic [23:0] q[$];
	int n_mismatch = 0;
	int n_tests = 0;
	int t;
	wire cs_n, sclk, serial_in, serial_out, oe_n, rdy, a0, a1, d0, d1, d2, d3, uni, cont;
	wire [23:0] cfgo;
	// Floating line never repeats the last bit, so stale data cannot pass
	wire pin = oe_n ? ~serial_out : serial_out;
	initial forever #12.5 clk = ~clk;
	asp_top u_asp_top (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_CS_N(cs_n), .I_SCLK(sclk),
		.I_SERIAL_IN(serial_in), .O_SERIAL_OUT(serial_out), .O_SERIAL_OUT_OE_N(oe_n), .I_CONV_DATA(din),
		.I_CONV_VALID(vld), .O_CONV_READY(rdy), .O_ANALOG_LATCH_OUT_0(a0),
		.O_ANALOG_LATCH_OUT_1(a1), .O_DIGITAL_LATCH_OUT_0(d0), .O_DIGITAL_LATCH_OUT_1(d1),
		.O_DIGITAL_LATCH_OUT_2(d2), .O_DIGITAL_LATCH_OUT_3(d3), .O_UNIPOLAR(uni),
		.O_CONT_MODE(cont), .O_CFG(cfgo));
	asp_host u_asp_host (.i_clk(clk), .i_sdo(pin), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(serial_in));
	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Watchdog, several times the expected run
	initial begin
		#2_000_000;
		n_mismatch++;
		stop_test;
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		repeat (4) @(posedge clk);
		chk({oe_n, serial_out, cfgo}, {2'b11, 24'h0});
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			rx = $random(seed);
			cfg = rx[23:0];
			cfg[10] = i[0];
			u_asp_host.xfer({8'h03, cfg}, 32, 0, rx);
			chk(cfgo, cfg);
			chk({a1, a0, d3, d2, d1, d0, uni}, {cfg[23:18], cfg[10]});
			u_asp_host.xfer({8'h0B, 24'h0}, 32, 0, rx);
			chk(rx[23:0], cfg);
		end
		$display("write and read test done");
		u_asp_host.xfer(32'hffff_ffff, 32, 1, rx);
		chk(cfgo, cfg);
		u_asp_host.xfer(32'h0000_3abc, 20, 0, rx);
		chk(cfgo, cfg);
		$display("deselect and abort test done");
		u_asp_host.xfer(32'h0000_00a0, 8, 0, rx);
		rx = $random(seed);
		din <= rx[23:0];
		vld <= 1;
		repeat (40) begin
			@(negedge clk);
			t = rdy;
			@(posedge clk);
			if (t) begin
				q.push_back(din);
				rx = $random(seed);
				din <= rx[23:0];
			end
		end
		vld <= 0;
		// Look at the ready flop away from the edge that updates it
		@(negedge clk);
		chk(rdy, 1'b0);
		while (q.size() > 0) begin
			t = 0;
			while (serial_out !== 1'b0 && t < 500) begin
				@(posedge clk);
				t++;
			end
			chk(serial_out, 1'b0);
			repeat (20) @(posedge clk);
			u_asp_host.xfer(32'h0, 32, 0, rx);
			chk(rx[23:0], q.pop_front());
		end
		repeat (100) @(posedge clk);
		chk({rdy, serial_out}, 2'b11);
		// One more word so the exit command meets a raised flag
		rx = $random(seed);
		din <= rx[23:0];
		vld <= 1;
		@(posedge clk);
		vld <= 0;
		t = 0;
		while (serial_out !== 1'b0 && t < 500) begin
			@(posedge clk);
			t++;
		end
		chk(serial_out, 1'b0);
		repeat (20) @(posedge clk);
		u_asp_host.xfer({8'h0B, 24'h0}, 32, 0, rx);
		chk({cont, rx[23:0]}, {1'b0, cfg});
		$display("continuous mode test done");
		stop_test;
	end
endmodule // tb_top
`default_nettype wire
